//--- rtl/mdf_defs.vh
// Behaviour
// - Full stack: a new interrupt still sets its request flag but is not acknowledged.
// - A held interrupt is taken once a return lowers the stack below full.
// - A call on a full stack drops the oldest entry; four newest addresses remain.
// - Data space has 113 byte locations: special registers plus general storage.
// - Special registers decode at fixed addresses 00H through 1EH.
// - General purpose bytes sit at 20H through 7FH.
// - Any byte takes arithmetic, logic, inc, dec, rotate and bit set/clear operations.
// - Access to 00H or 02H acts on the byte selected by pointer 0 or 1.
// - Indirect access aimed at an indirect port reads zero and writes nothing.
// - Moves between the two indirect ports are unsupported; result undefined.
// - Each indirect pointer holds a 7-bit address.
// - Pointer 0 reaches data memory only; pointer 1 also reaches segment memory.
// - Work register at 05H takes immediates and carries every memory-to-memory move.
// - 8-bit ALU: add, adc, sub, sbc, daa, and, or, xor, cpl, rotates, inc, dec, skips.
// - ALU operations write their result except sz and snz; rl, rr and the skips leave every flag unchanged.
// - Flag register is 8 bits: carry, half carry, zero, overflow, power-down, timeout.
// - Instruction writes to the flag register leave power-down and timeout unchanged.
// - Power-down and timeout change only on watchdog, power-up, clear or halt.
// - Zero, overflow, half carry and carry reflect the latest affecting operation.
// - Flag bits: C0, AC1, Z2, OV3, PDF4, TO5; bits 6 and 7 read zero.
// - Power-down clears on power-up/clear, sets on halt; timeout clears on power-up, clear or halt, sets on overflow.
`ifndef MDF_DEFS_VH
`define MDF_DEFS_VH
// ==========================================
// Address map
`define MDF_A_IND0 7'h00
`define MDF_A_PTR0 7'h01
`define MDF_A_IND1 7'h02
`define MDF_A_PTR1 7'h03
`define MDF_A_BANK 7'h04
`define MDF_A_ACC 7'h05
`define MDF_A_PCL 7'h06
`define MDF_A_TABLE_POINTER 7'h07
`define MDF_A_TABLE_HIGH_BYTE 7'h08
`define MDF_A_CLOCK_TICK_CONTROL 7'h09
`define MDF_A_FLAG 7'h0A
`define MDF_A_IRQ0 7'h0B
`define MDF_A_TMR 7'h0D
`define MDF_A_TIMER_CONTROL 7'h0E
`define MDF_A_PA 7'h12
`define MDF_A_PB 7'h14
`define MDF_A_IRQ1 7'h1E
`define MDF_A_GP_LO 7'h20
// ==========================================
// Flag and interrupt control bits
`define MDF_F_C 0
`define MDF_F_AC 1
`define MDF_F_Z 2
`define MDF_F_OV 3
`define MDF_F_PDF 4
`define MDF_F_TO 5
`define MDF_I0_EMI 0
`define MDF_I0_EEI0 1
`define MDF_I0_EEI1 2
`define MDF_I0_ETI 3
`define MDF_I0_EIF0 4
`define MDF_I0_EIF1 5
`define MDF_I0_TF 6
`define MDF_I1_ETBI 0
`define MDF_I1_ERTI 1
`define MDF_I1_TBF 4
`define MDF_I1_RTF 5
`define MDF_I0_MASK 8'h7F
`define MDF_I1_MASK 8'h33
`define MDF_RST_BYTE 8'h00
// ==========================================
// Interrupt vectors and stack
`define MDF_V_EXT0 11'h004
`define MDF_V_EXT1 11'h008
`define MDF_V_TMR 11'h00C
`define MDF_V_TBASE 11'h010
`define MDF_V_RTC 11'h014
`define MDF_STK_DEPTH 3'h4
// ==========================================
// Operation codes
`define MDF_OP_MOVA_M 5'h00
`define MDF_OP_MOVM_A 5'h01
`define MDF_OP_MOVA_I 5'h02
`define MDF_OP_ADD 5'h03
`define MDF_OP_ADC 5'h04
`define MDF_OP_SUB 5'h05
`define MDF_OP_SBC 5'h06
`define MDF_OP_DAA 5'h07
`define MDF_OP_AND 5'h08
`define MDF_OP_OR 5'h09
`define MDF_OP_XOR 5'h0A
`define MDF_OP_CPL 5'h0B
`define MDF_OP_RL 5'h0C
`define MDF_OP_RR 5'h0D
`define MDF_OP_RLC 5'h0E
`define MDF_OP_RRC 5'h0F
`define MDF_OP_INC 5'h10
`define MDF_OP_DEC 5'h11
`define MDF_OP_SZ 5'h12
`define MDF_OP_SNZ 5'h13
`define MDF_OP_SIZ 5'h14
`define MDF_OP_SDZ 5'h15
`define MDF_OP_SET 5'h16
`define MDF_OP_CLR 5'h17
`endif

//--- rtl/mdf_core.v
`timescale 1ns/10ps
`default_nettype none
`include "mdf_defs.vh"

module mdf_core
(
	input wire clk_in,
	input wire rst_in,
	input wire op_valid_in,
	input wire [4:0] op_code_in,
	input wire [6:0] op_addr_in,
	input wire [7:0] op_imm_in,
	input wire op_imm_sel_in,
	input wire op_to_acc_in,
	input wire [2:0] op_bit_in,
	input wire [10:0] pc_in,
	input wire call_in,
	input wire ret_in,
	input wire return_from_irq_op_in,
	input wire irq_ext0_in,
	input wire irq_ext1_in,
	input wire irq_timer_in,
	input wire irq_tbase_in,
	input wire irq_rtc_in,
	input wire [7:0] tbl_high_in,
	input wire wdt_clear_in,
	input wire halt_in,
	input wire wdt_timeout_in,
	output reg [7:0] acc_out,
	output reg [7:0] flags_out,
	output reg [7:0] result_out,
	output reg skip_out,
	output reg pcl_write_out,
	output reg lcd_write_out,
	output reg [6:0] lcd_addr_out,
	output reg [7:0] lcd_data_out,
	output reg irq_ack_out,
	output reg [10:0] irq_vector_out,
	output reg stack_full_out,
	output reg ret_valid_out,
	output reg [10:0] ret_addr_out
);

	// ==========================================
	// Storage
	reg [6:0] ptr0;
	reg [6:0] ptr1;
	reg [7:0] bank;
	reg [7:0] table_pointer;
	reg [7:0] clock_tick_control;
	reg [7:0] irq0;
	reg [7:0] tmr;
	reg [7:0] timer_control;
	reg [7:0] pa;
	reg [7:0] pb;
	reg [7:0] irq1;
	reg f_c;
	reg f_ac;
	reg f_z;
	reg f_ov;
	reg f_pdf;
	reg f_to;
	reg [7:0] gp_mem [32:127];
	reg [7:0] lcd_mem [0:127];
	reg [10:0] stk [0:3];
	reg [1:0] stk_head;
	reg [2:0] stk_count;

	// ==========================================
	// Address resolution
	wire ind0 = (op_addr_in == `MDF_A_IND0);
	wire ind1 = (op_addr_in == `MDF_A_IND1);
	// Port-to-port moves get no special case; the result is whatever the mux gives
	wire [6:0] ea = ind0 ? ptr0 : (ind1 ? ptr1 : op_addr_in);
	// Pointer aimed back at a port has no target at all
	wire null_ea = (ind0 | ind1) && (ea == `MDF_A_IND0 || ea == `MDF_A_IND1);
	// Only pointer 1 with bank bit 0 set reaches segment memory
	wire lcd_ea = ind1 && bank[0];
	wire [7:0] flag_byte = {2'b00, f_to, f_pdf, f_ov, f_z, f_ac, f_c};

	reg [7:0] rd_val;
	always @*
	begin
		rd_val = `MDF_RST_BYTE;
		if (null_ea)
			rd_val = `MDF_RST_BYTE;
		else if (lcd_ea)
			rd_val = lcd_mem[ea];
		else if (ea >= `MDF_A_GP_LO)
			rd_val = gp_mem[ea];
		else
		begin
			case (ea)
				`MDF_A_PTR0: rd_val = {1'b0, ptr0};
				`MDF_A_PTR1: rd_val = {1'b0, ptr1};
				`MDF_A_BANK: rd_val = bank;
				`MDF_A_ACC: rd_val = acc_out;
				`MDF_A_PCL: rd_val = pc_in[7:0];
				`MDF_A_TABLE_POINTER: rd_val = table_pointer;
				`MDF_A_TABLE_HIGH_BYTE: rd_val = tbl_high_in;
				`MDF_A_CLOCK_TICK_CONTROL: rd_val = clock_tick_control;
				`MDF_A_FLAG: rd_val = flag_byte;
				`MDF_A_IRQ0: rd_val = irq0 & `MDF_I0_MASK;
				`MDF_A_TMR: rd_val = tmr;
				`MDF_A_TIMER_CONTROL: rd_val = timer_control;
				`MDF_A_PA: rd_val = pa;
				`MDF_A_PB: rd_val = pb;
				`MDF_A_IRQ1: rd_val = irq1 & `MDF_I1_MASK;
				default: rd_val = `MDF_RST_BYTE;
			endcase
		end
	end

	// ==========================================
	// Arithmetic and logic
	wire [7:0] a = acc_out;
	wire [7:0] b = op_imm_sel_in ? op_imm_in : rd_val;
	reg [7:0] res;
	reg [7:0] bb;
	reg cin;
	reg [8:0] s;
	reg [4:0] h;
	reg n_c;
	reg n_ac;
	reg n_ov;
	reg upd_arith;
	reg upd_c;
	reg upd_z;
	reg skip;
	reg to_acc;
	reg writes;
	reg [7:0] daa_lo;

	always @*
	begin
		bb = b;
		cin = 1'b0;
		s = 9'h000;
		h = 5'h00;
		res = b;
		n_c = f_c;
		n_ac = f_ac;
		n_ov = f_ov;
		upd_arith = 1'b0;
		upd_c = 1'b0;
		upd_z = 1'b0;
		skip = 1'b0;
		to_acc = op_to_acc_in;
		writes = 1'b1;
		daa_lo = a;
		case (op_code_in)
			`MDF_OP_MOVA_M, `MDF_OP_MOVA_I:
			begin
				res = b;
				to_acc = 1'b1;
			end
			`MDF_OP_MOVM_A:
			begin
				res = a;
				to_acc = 1'b0;
			end
			`MDF_OP_ADD, `MDF_OP_ADC, `MDF_OP_SUB, `MDF_OP_SBC:
			begin
				// Subtraction adds the inverse so carry means no borrow
				if (op_code_in == `MDF_OP_SUB || op_code_in == `MDF_OP_SBC)
					bb = ~b;
				if (op_code_in == `MDF_OP_SUB)
					cin = 1'b1;
				else if (op_code_in != `MDF_OP_ADD)
					cin = f_c;
				s = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
				h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
				res = s[7:0];
				n_c = s[8];
				n_ac = h[4];
				n_ov = (a[7] == bb[7]) && (s[7] != a[7]);
				upd_arith = 1'b1;
				upd_z = 1'b1;
			end
			`MDF_OP_DAA:
			begin
				if (a[3:0] > 4'h9 || f_ac)
					daa_lo = a + 8'h06;
				s = {1'b0, daa_lo};
				if (daa_lo[7:4] > 4'h9 || f_c || (a[3:0] > 4'h9 && a[7:4] == 4'h9))
					s = {1'b0, daa_lo} + 9'h060;
				res = s[7:0];
				n_c = s[8] | f_c;
				upd_c = 1'b1;
				to_acc = 1'b0;
			end
			`MDF_OP_AND:
			begin
				res = a & b;
				upd_z = 1'b1;
			end
			`MDF_OP_OR:
			begin
				res = a | b;
				upd_z = 1'b1;
			end
			`MDF_OP_XOR:
			begin
				res = a ^ b;
				upd_z = 1'b1;
			end
			`MDF_OP_CPL:
			begin
				res = ~b;
				upd_z = 1'b1;
			end
			`MDF_OP_RL: res = {b[6:0], b[7]};
			`MDF_OP_RR: res = {b[0], b[7:1]};
			`MDF_OP_RLC:
			begin
				res = {b[6:0], f_c};
				n_c = b[7];
				upd_c = 1'b1;
			end
			`MDF_OP_RRC:
			begin
				res = {f_c, b[7:1]};
				n_c = b[0];
				upd_c = 1'b1;
			end
			`MDF_OP_INC:
			begin
				res = b + 8'h01;
				upd_z = 1'b1;
			end
			`MDF_OP_DEC:
			begin
				res = b - 8'h01;
				upd_z = 1'b1;
			end
			`MDF_OP_SZ:
			begin
				writes = 1'b0;
				skip = (b == 8'h00);
			end
			`MDF_OP_SNZ:
			begin
				writes = 1'b0;
				skip = (b != 8'h00);
			end
			`MDF_OP_SIZ:
			begin
				res = b + 8'h01;
				skip = (res == 8'h00);
			end
			`MDF_OP_SDZ:
			begin
				res = b - 8'h01;
				skip = (res == 8'h00);
			end
			`MDF_OP_SET, `MDF_OP_CLR:
			begin
				res = b;
				res[op_bit_in] = (op_code_in == `MDF_OP_SET);
				to_acc = 1'b0;
			end
			default: writes = 1'b0;
		endcase
	end

	wire wr_acc = op_valid_in && writes && to_acc;
	wire wr_mem = op_valid_in && writes && !to_acc && !null_ea;
	wire wr_gp = wr_mem && !lcd_ea && (ea >= `MDF_A_GP_LO);
	wire wr_lcd = wr_mem && lcd_ea;

	// ==========================================
	// Stack and interrupt arbitration
	wire stk_full = (stk_count == `MDF_STK_DEPTH);
	wire pop = ret_in | return_from_irq_op_in;
	wire p_ext0 = irq0[`MDF_I0_EEI0] & irq0[`MDF_I0_EIF0];
	wire p_ext1 = irq0[`MDF_I0_EEI1] & irq0[`MDF_I0_EIF1];
	wire p_tmr = irq0[`MDF_I0_ETI] & irq0[`MDF_I0_TF];
	wire p_tb = irq1[`MDF_I1_ETBI] & irq1[`MDF_I1_TBF];
	wire p_rtc = irq1[`MDF_I1_ERTI] & irq1[`MDF_I1_RTF];
	// Full stack holds acknowledgement; it resumes the cycle after a pop
	wire ack = irq0[`MDF_I0_EMI] && (p_ext0 | p_ext1 | p_tmr | p_tb | p_rtc)
		&& !stk_full && !call_in && !pop;
	wire push = call_in | ack;

	reg [2:0] next_count;
	always @*
	begin
		next_count = stk_count;
		if (push)
			next_count = stk_full ? stk_count : stk_count + 3'h1;
		else if (pop && stk_count != 3'h0)
			next_count = stk_count - 3'h1;
	end

	// ==========================================
	// Memories without reset
	always @(posedge clk_in)
	begin
		if (wr_gp)
			gp_mem[ea] <= res;
		if (wr_lcd)
			lcd_mem[ea] <= res;
		// Circular slot overwrite drops the oldest address when full
		if (push)
			stk[stk_head] <= pc_in;
	end

	// ==========================================
	// Registers with reset
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ptr0 <= 7'h00;
			ptr1 <= 7'h00;
			bank <= `MDF_RST_BYTE;
			table_pointer <= `MDF_RST_BYTE;
			clock_tick_control <= `MDF_RST_BYTE;
			irq0 <= `MDF_RST_BYTE;
			tmr <= `MDF_RST_BYTE;
			timer_control <= `MDF_RST_BYTE;
			pa <= `MDF_RST_BYTE;
			pb <= `MDF_RST_BYTE;
			irq1 <= `MDF_RST_BYTE;
			f_c <= 1'b0;
			f_ac <= 1'b0;
			f_z <= 1'b0;
			f_ov <= 1'b0;
			f_pdf <= 1'b0;
			f_to <= 1'b0;
			stk_head <= 2'h0;
			stk_count <= 3'h0;
			acc_out <= `MDF_RST_BYTE;
			flags_out <= `MDF_RST_BYTE;
			result_out <= `MDF_RST_BYTE;
			skip_out <= 1'b0;
			pcl_write_out <= 1'b0;
			lcd_write_out <= 1'b0;
			lcd_addr_out <= 7'h00;
			lcd_data_out <= `MDF_RST_BYTE;
			irq_ack_out <= 1'b0;
			irq_vector_out <= 11'h000;
			stack_full_out <= 1'b0;
			ret_valid_out <= 1'b0;
			ret_addr_out <= 11'h000;
		end
		else
		begin
			skip_out <= op_valid_in & skip;
			pcl_write_out <= wr_mem && !lcd_ea && (ea == `MDF_A_PCL);
			lcd_write_out <= wr_lcd;
			if (wr_lcd)
			begin
				lcd_addr_out <= ea;
				lcd_data_out <= res;
			end
			if (op_valid_in && writes)
				result_out <= res;
			if (wr_acc)
				acc_out <= res;
			if (wr_mem && !lcd_ea)
			begin
				case (ea)
					`MDF_A_PTR0: ptr0 <= res[6:0];
					`MDF_A_PTR1: ptr1 <= res[6:0];
					`MDF_A_BANK: bank <= res;
					`MDF_A_ACC: acc_out <= res;
					`MDF_A_TABLE_POINTER: table_pointer <= res;
					`MDF_A_CLOCK_TICK_CONTROL: clock_tick_control <= res;
					`MDF_A_FLAG:
					begin
						// Power-down and timeout bits are not written here
						f_c <= res[`MDF_F_C];
						f_ac <= res[`MDF_F_AC];
						f_z <= res[`MDF_F_Z];
						f_ov <= res[`MDF_F_OV];
					end
					`MDF_A_IRQ0: irq0 <= res & `MDF_I0_MASK;
					`MDF_A_TMR: tmr <= res;
					`MDF_A_TIMER_CONTROL: timer_control <= res;
					`MDF_A_PA: pa <= res;
					`MDF_A_PB: pb <= res;
					`MDF_A_IRQ1: irq1 <= res & `MDF_I1_MASK;
					default: ;
				endcase
			end
			// Operation flags override a write to the flag register
			if (op_valid_in && upd_arith)
			begin
				f_ac <= n_ac;
				f_ov <= n_ov;
			end
			if (op_valid_in && (upd_arith | upd_c))
				f_c <= n_c;
			if (op_valid_in && upd_z)
				f_z <= (res == 8'h00);
			if (wdt_clear_in | halt_in)
				f_to <= 1'b0;
			if (wdt_timeout_in)
				f_to <= 1'b1;
			if (wdt_clear_in)
				f_pdf <= 1'b0;
			if (halt_in)
				f_pdf <= 1'b1;
			flags_out <= flag_byte;
			// Acknowledge: clear chosen request and master enable
			irq_ack_out <= ack;
			if (ack)
			begin
				irq0[`MDF_I0_EMI] <= 1'b0;
				if (p_ext0)
				begin
					irq0[`MDF_I0_EIF0] <= 1'b0;
					irq_vector_out <= `MDF_V_EXT0;
				end
				else if (p_ext1)
				begin
					irq0[`MDF_I0_EIF1] <= 1'b0;
					irq_vector_out <= `MDF_V_EXT1;
				end
				else if (p_tmr)
				begin
					irq0[`MDF_I0_TF] <= 1'b0;
					irq_vector_out <= `MDF_V_TMR;
				end
				else if (p_tb)
				begin
					irq1[`MDF_I1_TBF] <= 1'b0;
					irq_vector_out <= `MDF_V_TBASE;
				end
				else
				begin
					irq1[`MDF_I1_RTF] <= 1'b0;
					irq_vector_out <= `MDF_V_RTC;
				end
			end
			if (return_from_irq_op_in)
				irq0[`MDF_I0_EMI] <= 1'b1;
			// Requests latch even while the stack is full; set beats clear
			if (irq_ext0_in)
				irq0[`MDF_I0_EIF0] <= 1'b1;
			if (irq_ext1_in)
				irq0[`MDF_I0_EIF1] <= 1'b1;
			if (irq_timer_in)
				irq0[`MDF_I0_TF] <= 1'b1;
			if (irq_tbase_in)
				irq1[`MDF_I1_TBF] <= 1'b1;
			if (irq_rtc_in)
				irq1[`MDF_I1_RTF] <= 1'b1;
			// Stack pointer; flags are never stacked with the address
			stk_count <= next_count;
			stack_full_out <= (next_count == `MDF_STK_DEPTH);
			ret_valid_out <= pop && !push && stk_count != 3'h0;
			if (push)
				stk_head <= stk_head + 2'h1;
			else if (pop && stk_count != 3'h0)
			begin
				stk_head <= stk_head - 2'h1;
				ret_addr_out <= stk[stk_head - 2'h1];
			end
		end
	end

endmodule // mdf_core
`default_nettype wire

//--- bench/mdf_core_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "mdf_defs.vh"
module mdf_core_props
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic op_valid_in,
	input wire logic [4:0] op_code_in,
	input wire logic [6:0] op_addr_in,
	input wire logic call_in,
	input wire logic ret_in,
	input wire logic return_from_irq_op_in,
	input wire logic wdt_clear_in,
	input wire logic halt_in,
	input wire logic wdt_timeout_in,
	input wire logic [7:0] flags_out,
	input wire logic skip_out,
	input wire logic pcl_write_out,
	input wire logic lcd_write_out,
	input wire logic irq_ack_out,
	input wire logic [10:0] irq_vector_out,
	input wire logic stack_full_out,
	input wire logic ret_valid_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// ==========================================
	// Checks
	a_flag_pad_zero: assert property (flags_out[7:6] == 2'b00)
		else $error("flag pad bits set");
	a_full_no_ack: assert property (irq_ack_out |-> !$past(stack_full_out))
		else $error("ack while stack full");
	a_ack_vector_legal: assert property (irq_ack_out |-> irq_vector_out inside
		{11'h004, 11'h008, 11'h00C, 11'h010, 11'h014})
		else $error("bad vector");
	a_ack_quiet_cycle: assert property (irq_ack_out |-> !$past(call_in || ret_in || return_from_irq_op_in))
		else $error("ack beside call or pop");
	a_pop_source: assert property (ret_valid_out |-> $past(ret_in || return_from_irq_op_in) && !$past(call_in))
		else $error("pop without return");
	a_full_source: assert property ($rose(stack_full_out) |-> $past(call_in) || irq_ack_out)
		else $error("stack filled without push");
	a_pdf_cause: assert property ($changed(flags_out[4]) |-> $past(wdt_clear_in || halt_in, 2))
		else $error("power-down flag moved");
	a_to_set_cause: assert property ($rose(flags_out[5]) |-> $past(wdt_timeout_in, 2))
		else $error("timeout flag set without overflow");
	a_skip_source: assert property (skip_out |-> $past(op_valid_in)
		&& $past(op_code_in) >= `MDF_OP_SZ && $past(op_code_in) <= `MDF_OP_SDZ)
		else $error("skip without skip op");
	a_lcd_via_port1: assert property (lcd_write_out |-> $past(op_valid_in)
		&& $past(op_addr_in) == `MDF_A_IND1)
		else $error("segment write not through port 1");
	a_pcl_write_source: assert property (pcl_write_out |-> $past(op_valid_in)
		&& $past(op_addr_in) inside {7'h00, 7'h02, 7'h06})
		else $error("low byte write without op");
	c_ack: cover property (irq_ack_out);
	c_lcd: cover property (lcd_write_out);
	c_call_full: cover property (stack_full_out && call_in);
endmodule // mdf_core_props
`default_nettype wire

//--- bench/tb_mcu_data_memory_and_flags.sv
`timescale 1ns/10ps
`default_nettype none
`include "mdf_defs.vh"
module tb_mcu_data_memory_and_flags;
	logic clk_in, rst_in, op_valid_in, op_imm_sel_in, op_to_acc_in, call_in, ret_in, return_from_irq_op_in;
	logic irq_ext0_in, wdt_clear_in, halt_in, wdt_timeout_in, last_skip;
	logic irq_timer_in, last_pcl, last_lcd;
	logic [7:0] result_out;
	logic [4:0] alu_ops [7];
	logic [8:0] e9;
	logic [4:0] op_code_in;
	logic [6:0] op_addr_in, ga;
	logic [7:0] op_imm_in, tbl_high_in, a, b, d;
	logic [2:0] op_bit_in;
	logic [10:0] pc_in, irq_vector_out, ret_addr_out, exp_pop [4];
	logic [7:0] acc_out, flags_out, lcd_data_out;
	logic [6:0] lcd_addr_out;
	logic skip_out, pcl_write_out, lcd_write_out, irq_ack_out, stack_full_out, ret_valid_out;
	logic [31:0] rng;
	int fail_count, checks, k;
	mdf_core mdf_core_inst (.clk_in(clk_in), .rst_in(rst_in), .op_valid_in(op_valid_in),
		.op_code_in(op_code_in), .op_addr_in(op_addr_in), .op_imm_in(op_imm_in),
		.op_imm_sel_in(op_imm_sel_in), .op_to_acc_in(op_to_acc_in), .op_bit_in(op_bit_in),
		.pc_in(pc_in), .call_in(call_in), .ret_in(ret_in), .return_from_irq_op_in(return_from_irq_op_in),
		.irq_ext0_in(irq_ext0_in), .irq_ext1_in(1'b0), .irq_timer_in(irq_timer_in),
		.irq_tbase_in(1'b0), .irq_rtc_in(1'b0), .tbl_high_in(tbl_high_in),
		.wdt_clear_in(wdt_clear_in), .halt_in(halt_in), .wdt_timeout_in(wdt_timeout_in),
		.acc_out(acc_out), .flags_out(flags_out), .result_out(result_out), .skip_out(skip_out),
		.pcl_write_out(pcl_write_out), .lcd_write_out(lcd_write_out),
		.lcd_addr_out(lcd_addr_out), .lcd_data_out(lcd_data_out), .irq_ack_out(irq_ack_out),
		.irq_vector_out(irq_vector_out), .stack_full_out(stack_full_out),
		.ret_valid_out(ret_valid_out), .ret_addr_out(ret_addr_out));
	// ==========================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [7:0] add_flags(input logic [7:0] x, input logic [7:0] y);
		logic [8:0] s;
		s = {1'b0, x} + {1'b0, y};
		return {4'h0, (x[7] == y[7]) && (s[7] != x[7]), s[7:0] == 8'h00,
			({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'h0F, s[8]};
	endfunction
	// Returns {carry, result}; carry set on subtract means no borrow
	function automatic logic [8:0] ref_alu(input logic [4:0] c, input logic [7:0] x,
		input logic [7:0] y, input logic ci);
		case (c)
			`MDF_OP_SUB: return {1'b0, x} + {1'b0, ~y} + 9'h001;
			`MDF_OP_AND: return {ci, x & y};
			`MDF_OP_OR: return {ci, x | y};
			`MDF_OP_XOR: return {ci, x ^ y};
			`MDF_OP_RLC: return {y, ci};
			`MDF_OP_RRC: return {y[0], ci, y[7:1]};
			default: return {ci, y - 8'h01};
		endcase
	endfunction
	task automatic tick();
		@(posedge clk_in);
		#2;
	endtask
	task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
		checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// Idle cycle after each op lets the lagging flag byte settle before any check
	task automatic op(input logic [4:0] c, input logic [6:0] ad, input logic [7:0] i,
		input logic s, input logic t, input logic [2:0] bt);
		op_code_in = c;
		op_addr_in = ad;
		op_imm_in = i;
		op_imm_sel_in = s;
		op_to_acc_in = t;
		op_bit_in = bt;
		op_valid_in = 1'b1;
		tick();
		op_valid_in = 1'b0;
		last_skip = skip_out;
		last_pcl = pcl_write_out;
		last_lcd = lcd_write_out;
		tick();
	endtask
	task automatic wr(input logic [6:0] ad, input logic [7:0] v);
		op(`MDF_OP_MOVA_I, 7'h00, v, 1'b1, 1'b1, 3'h0);
		op(`MDF_OP_MOVM_A, ad, 8'h00, 1'b0, 1'b0, 3'h0);
	endtask
	task automatic rd(input logic [6:0] ad);
		op(`MDF_OP_MOVA_M, ad, 8'h00, 1'b0, 1'b1, 3'h0);
	endtask
	task automatic close_out();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ==========================================
	// Clock, watchdog, sequence
	initial
	begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	initial
	begin
		#(50 * 8000);
		fail_count++;
		close_out();
	end
	initial
	begin
		{op_valid_in, op_imm_sel_in, op_to_acc_in, call_in, ret_in, return_from_irq_op_in} = 6'h00;
		{irq_ext0_in, irq_timer_in, wdt_clear_in, halt_in, wdt_timeout_in} = 5'h00;
		{op_code_in, op_addr_in, op_imm_in, op_bit_in, pc_in} = 34'h0;
		rng = 32'h2c5882c9;
		tbl_high_in = rng[7:0];
		rst_in = 1'b1;
		repeat (20) @(posedge clk_in);
		#2 rst_in = 1'b0;
		chk("flags reset", 11'h000, {3'h0, flags_out});
		wr(7'h05, 8'hFF);
		op(`MDF_OP_ADD, 7'h00, 8'h01, 1'b1, 1'b1, 3'h0);
		chk("acc", 11'h000, {3'h0, acc_out});
		chk("flags", 11'h007, {3'h0, flags_out});
		for (k = 0; k < 16; k++)
		begin
			rng = lfsr(rng);
			a = rng[7:0];
			b = rng[15:8];
			d = rng[23:16];
			ga = 7'h20 + 7'(rng[31:24] % 96);
			op(`MDF_OP_MOVA_I, 7'h00, a, 1'b1, 1'b1, 3'h0);
			op(`MDF_OP_ADD, 7'h00, b, 1'b1, 1'b1, 3'h0);
			chk("add acc", {3'h0, a + b}, {3'h0, acc_out});
			chk("add flags", {3'h0, add_flags(a, b)}, {3'h0, flags_out});
			wr(ga, d);
			op(`MDF_OP_SET, ga, 8'h00, 1'b0, 1'b0, rng[2:0]);
			rd(ga);
			chk("gp byte", {3'h0, d | (8'h01 << rng[2:0])}, {3'h0, acc_out});
			wr(`MDF_A_PTR0, {1'b0, ga});
			rd(`MDF_A_IND0);
			chk("indirect 0", {3'h0, d | (8'h01 << rng[2:0])}, {3'h0, acc_out});
		end
		alu_ops = '{`MDF_OP_SUB, `MDF_OP_AND, `MDF_OP_OR, `MDF_OP_XOR, `MDF_OP_RLC,
			`MDF_OP_RRC, `MDF_OP_DEC};
		for (k = 0; k < 14; k++)
		begin
			rng = lfsr(rng);
			e9 = ref_alu(alu_ops[k % 7], rng[7:0], rng[15:8], rng[16]);
			wr(`MDF_A_FLAG, {7'h00, rng[16]});
			op(`MDF_OP_MOVA_I, 7'h00, rng[7:0], 1'b1, 1'b1, 3'h0);
			op(alu_ops[k % 7], 7'h00, rng[15:8], 1'b1, 1'b1, 3'h0);
			chk("alu acc", {3'h0, e9[7:0]}, {3'h0, acc_out});
			chk("alu carry", {10'h0, e9[8]}, {10'h0, flags_out[0]});
		end
		wr(`MDF_A_PTR0, 8'h00);
		wr(`MDF_A_IND0, 8'h55);
		rd(`MDF_A_IND0);
		chk("self indirect", 11'h000, {3'h0, acc_out});
		wr(7'h0C, 8'hAA);
		rd(7'h0C);
		chk("unused sfr", 11'h000, {3'h0, acc_out});
		op(`MDF_OP_SZ, 7'h0C, 8'h00, 1'b0, 1'b1, 3'h0);
		chk("skip", 11'h001, {10'h0, last_skip});
		wr(`MDF_A_TABLE_HIGH_BYTE, ~tbl_high_in);
		rd(`MDF_A_TABLE_HIGH_BYTE);
		chk("table high", {3'h0, tbl_high_in}, {3'h0, acc_out});
		wr(`MDF_A_PCL, 8'h33);
		chk("pcl strobe", 11'h001, {10'h0, last_pcl});
		chk("pcl byte", 11'h033, {3'h0, result_out});
		wr(`MDF_A_FLAG, 8'hFF);
		chk("flag write", 11'h00F, {3'h0, flags_out});
		halt_in = 1'b1;
		tick();
		halt_in = 1'b0;
		wdt_timeout_in = 1'b1;
		tick();
		wdt_timeout_in = 1'b0;
		tick();
		chk("halt timeout", 11'h03F, {3'h0, flags_out});
		wr(`MDF_A_FLAG, 8'h00);
		chk("flag keep", 11'h030, {3'h0, flags_out});
		wdt_clear_in = 1'b1;
		tick();
		wdt_clear_in = 1'b0;
		tick();
		chk("wdt clear", 11'h000, {3'h0, flags_out});
		wr(`MDF_A_BANK, 8'h01);
		wr(`MDF_A_PTR1, 8'h05);
		wr(`MDF_A_IND1, 8'h5A);
		chk("seg strobe", 11'h001, {10'h0, last_lcd});
		chk("seg addr", 11'h005, {4'h0, lcd_addr_out});
		chk("seg data", 11'h05A, {3'h0, lcd_data_out});
		wr(`MDF_A_BANK, 8'h00);
		// Stack and held interrupt
		wr(`MDF_A_IRQ0, 8'h03);
		for (k = 0; k < 4; k++)
		begin
			pc_in = 11'h100 + 11'(k);
			call_in = 1'b1;
			tick();
			call_in = 1'b0;
			tick();
		end
		chk("full", 11'h001, {10'h0, stack_full_out});
		// Flags changed inside the routine must survive the returns
		wr(`MDF_A_FLAG, 8'h05);
		irq_ext0_in = 1'b1;
		irq_timer_in = 1'b1;
		tick();
		irq_ext0_in = 1'b0;
		irq_timer_in = 1'b0;
		rd(`MDF_A_IRQ0);
		chk("held flag", 11'h053, {3'h0, acc_out});
		pc_in = 11'h200;
		ret_in = 1'b1;
		tick();
		ret_in = 1'b0;
		chk("pop valid", 11'h001, {10'h0, ret_valid_out});
		chk("pop addr", 11'h103, ret_addr_out);
		tick();
		chk("ack", 11'h001, {10'h0, irq_ack_out});
		chk("vector", `MDF_V_EXT0, irq_vector_out);
		tick();
		pc_in = 11'h300;
		call_in = 1'b1;
		tick();
		call_in = 1'b0;
		tick();
		exp_pop = '{11'h300, 11'h200, 11'h102, 11'h101};
		for (k = 0; k < 5; k++)
		begin
			ret_in = k[0];
			return_from_irq_op_in = ~k[0];
			tick();
			{ret_in, return_from_irq_op_in} = 2'b00;
			chk("pop valid", {10'h0, k < 4}, {10'h0, ret_valid_out});
			if (k < 4)
				chk("pop addr", exp_pop[k], ret_addr_out);
			tick();
		end
		chk("flags unstacked", 11'h005, {3'h0, flags_out});
		// Latched timer request is taken once its enable is written
		wr(`MDF_A_IRQ0, 8'h49);
		chk("timer ack", 11'h001, {10'h0, irq_ack_out});
		chk("timer vector", `MDF_V_TMR, irq_vector_out);
		close_out();
	end
endmodule // tb_mcu_data_memory_and_flags
bind mdf_core mdf_core_props mdf_core_props_inst (.clk_in(clk_in), .rst_in(rst_in),
	.op_valid_in(op_valid_in), .op_code_in(op_code_in), .op_addr_in(op_addr_in),
	.call_in(call_in), .ret_in(ret_in), .return_from_irq_op_in(return_from_irq_op_in), .wdt_clear_in(wdt_clear_in),
	.halt_in(halt_in), .wdt_timeout_in(wdt_timeout_in), .flags_out(flags_out),
	.skip_out(skip_out), .pcl_write_out(pcl_write_out), .lcd_write_out(lcd_write_out),
	.irq_ack_out(irq_ack_out), .irq_vector_out(irq_vector_out),
	.stack_full_out(stack_full_out), .ret_valid_out(ret_valid_out));
`default_nettype wire
